// >>> inc/thermal_profile_pkg.sv
/*
 * Shared constants and types of the thermal charge profile register bank:
 * register offsets, reset values, field layout, zone codes and scaling.
 * Assumes a single 100 MHz core clock and 8-bit register data.
 */
package thermal_profile_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADJUST_OFFSET = 8'h61;
  localparam logic [7:0] COLD_OFFSET = 8'h62;
  localparam logic [7:0] COOL_OFFSET = 8'h63;
  localparam logic [7:0] WARM_OFFSET = 8'h64;
  localparam logic [7:0] ADJUST_RESET = 8'h34;
  localparam logic [7:0] COLD_RESET = 8'h7C;
  localparam logic [7:0] COOL_RESET = 8'h6D;
  localparam logic [7:0] WARM_RESET = 8'h38;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions inside the adjustment register
  // ----------------------------------------------------------------------
  localparam int DROP_SEL_LSB = 4;
  localparam int SCALE_SEL_LSB = 0;

  // ----------------------------------------------------------------------
  // Scaling of codes into physical units
  // ----------------------------------------------------------------------
  localparam int THRESH_LSB_UV = 4688;
  localparam logic [5:0] DROP_STEP_MV = 6'h32;
  localparam logic [3:0] SCALE_FULL = 4'h8;
  localparam int SCALE_SHIFT = 3;

  // ----------------------------------------------------------------------
  // Serial port constants
  // ----------------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2A;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rsvd_hi;
    logic [2:0] warm_voltage_drop_sel;
    logic rsvd_lo;
    logic [2:0] thermal_current_scale_sel;
  } adjust_t;

  typedef struct packed {
    adjust_t thermal_charge_adjust;
    logic [7:0] lowest_temp_limit;
    logic [7:0] chill_temp_limit;
    logic [7:0] elevated_temp_limit;
  } profile_regs_t;

  typedef enum logic [1:0] {
    ZONE_NORMAL = 2'b00,
    ZONE_COOL = 2'b01,
    ZONE_WARM = 2'b11,
    ZONE_COLD = 2'b10
  } zone_t;

  typedef enum logic [2:0] {
    PORT_IDLE = 3'b000,
    PORT_RX = 3'b001,
    PORT_ACK = 3'b011,
    PORT_TX = 3'b010,
    PORT_ACK_IN = 3'b110
  } port_state_t;

endpackage : thermal_profile_pkg

// >>> verilog/temp_zone_eval.sv
/*
 * Temperature zone evaluation: compares the sensed thermistor code with the
 * limit registers and derives the regulation drop and current scaling.
 * Assumes ts_code_in comes from logic on the same clock.
 */
`timescale 1ns/10ps

module temp_zone_eval #(
  parameter int CUR_W = 10
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] ts_code_in,
  input wire thermal_profile_pkg::profile_regs_t regs_in,
  input wire logic [CUR_W-1:0] programmed_fast_current_in,
  output thermal_profile_pkg::zone_t zone_out,
  output logic [8:0] vbat_drop_mv_out,
  output logic [CUR_W-1:0] fast_current_out,
  output logic charge_hold_out
);
  import thermal_profile_pkg::*;

  zone_t zone_reg, zone_next;
  logic [8:0] drop_reg, drop_next;
  logic [CUR_W-1:0] cur_reg, cur_next;
  logic hold_reg, hold_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Code n keeps (8-n)/8 of the current; zero keeps all of it
  function automatic logic [CUR_W-1:0] scale_current(
    input logic [CUR_W-1:0] cur,
    input logic [2:0] sel
  );
    logic [CUR_W+3:0] prod;
    prod = {4'h0, cur} * {{CUR_W{1'b0}}, (SCALE_FULL - {1'b0, sel})};
    return prod[CUR_W+SCALE_SHIFT-1:SCALE_SHIFT];
  endfunction : scale_current

  // ----------------------------------------------------------------------
  // Zone decision and applied reductions
  // ----------------------------------------------------------------------
  // NTC: a higher sensed code means a colder pack
  always_comb begin
    zone_next = ZONE_NORMAL;
    if (ts_code_in >= regs_in.lowest_temp_limit) begin
      zone_next = ZONE_COLD;
    end else if (ts_code_in >= regs_in.chill_temp_limit) begin
      zone_next = ZONE_COOL;
    end else if (ts_code_in <= regs_in.elevated_temp_limit) begin
      zone_next = ZONE_WARM;
    end
    drop_next = 9'h000;
    cur_next = programmed_fast_current_in;
    hold_next = (zone_next == ZONE_COLD);
    if (zone_next == ZONE_WARM) begin
      // Each code step lowers the target another 50 mV
      // Widen both factors first: seven steps of 50 mV overflow six bits
      drop_next = 9'(regs_in.thermal_charge_adjust.warm_voltage_drop_sel) *
        9'(DROP_STEP_MV);
    end
    if (zone_next == ZONE_WARM || zone_next == ZONE_COOL) begin
      cur_next = scale_current(programmed_fast_current_in,
        regs_in.thermal_charge_adjust.thermal_current_scale_sel);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zone_reg <= ZONE_NORMAL;
      drop_reg <= 9'h000;
      cur_reg <= '0;
      hold_reg <= 1'b0;
    end else begin
      zone_reg <= zone_next;
      drop_reg <= drop_next;
      cur_reg <= cur_next;
      hold_reg <= hold_next;
    end
  end

  assign zone_out = zone_reg;
  assign vbat_drop_mv_out = drop_reg;
  assign fast_current_out = cur_reg;
  assign charge_hold_out = hold_reg;

endmodule : temp_zone_eval

// >>> verilog/thermal_charge_profile_regs.sv
/*
 * Thermal charge profile register bank behind a two-wire serial slave port,
 * with the zone evaluation that uses it.
 * Assumes scl/sda arrive asynchronously from pins and are resolved as open
 * drain outside; ts code and current setting come from core-clock logic.
 */
`timescale 1ns/10ps

module thermal_charge_profile_regs #(
  parameter logic [6:0] DEV_ADDR = thermal_profile_pkg::DEFAULT_DEV_ADDR,
  parameter int CUR_W = 10
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] ts_code_in,
  input wire logic [CUR_W-1:0] programmed_fast_current_in,
  output thermal_profile_pkg::zone_t zone_out,
  output logic [8:0] vbat_drop_mv_out,
  output logic [CUR_W-1:0] fast_current_out,
  output logic charge_hold_out
);
  import thermal_profile_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Assert at once, release two edges later
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] scl_sync_reg, scl_sync_next;
  logic [2:0] sda_sync_reg, sda_sync_next;
  logic scl_lvl_reg, scl_lvl_next;
  logic sda_lvl_reg, sda_lvl_next;

  // Level only moves once stages two and three agree, hiding one-cycle glitches
  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_in};
    sda_sync_next = {sda_sync_reg[1:0], sda_in};
    scl_lvl_next = scl_lvl_reg;
    sda_lvl_next = sda_lvl_reg;
    if (scl_sync_reg[1] == scl_sync_reg[2]) begin
      scl_lvl_next = scl_sync_reg[2];
    end
    if (sda_sync_reg[1] == sda_sync_reg[2]) begin
      sda_lvl_next = sda_sync_reg[2];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'b111;
      sda_sync_reg <= 3'b111;
      scl_lvl_reg <= 1'b1;
      sda_lvl_reg <= 1'b1;
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_lvl_reg <= scl_lvl_next;
      sda_lvl_reg <= sda_lvl_next;
    end
  end

  // Bus events from the filtered levels
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_lvl_next & ~scl_lvl_reg;
  assign scl_fall = ~scl_lvl_next & scl_lvl_reg;
  assign start_cond = scl_lvl_reg & scl_lvl_next & sda_lvl_reg & ~sda_lvl_next;
  assign stop_cond = scl_lvl_reg & scl_lvl_next & ~sda_lvl_reg & sda_lvl_next;

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  // Unmapped offsets read as zero so a block read never stalls the host
  function automatic logic [7:0] read_reg(
    input profile_regs_t r,
    input logic [7:0] ofs
  );
    case (ofs)
      ADJUST_OFFSET: read_reg = r.thermal_charge_adjust;
      COLD_OFFSET: read_reg = r.lowest_temp_limit;
      COOL_OFFSET: read_reg = r.chill_temp_limit;
      WARM_OFFSET: read_reg = r.elevated_temp_limit;
      default: read_reg = UNMAPPED_READ;
    endcase
  endfunction : read_reg

  // ----------------------------------------------------------------------
  // Serial slave and register file
  // ----------------------------------------------------------------------
  port_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [1:0] byte_idx_reg, byte_idx_next;
  logic rd_reg, rd_next;
  logic nack_reg, nack_next;
  logic sda_oe_reg, sda_oe_next;
  profile_regs_t regs_reg, regs_next;

  // Address byte, then pointer byte, then data with pointer auto-increment
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    byte_idx_next = byte_idx_reg;
    rd_next = rd_reg;
    nack_next = nack_reg;
    regs_next = regs_reg;
    if (start_cond) begin
      // Repeated start keeps the pointer for write-then-read
      state_next = PORT_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = 2'd0;
    end else if (stop_cond) begin
      state_next = PORT_IDLE;
    end else begin
      case (state_reg)
        PORT_IDLE: begin
          state_next = PORT_IDLE;
        end
        PORT_RX: begin
          if (scl_rise && bit_cnt_reg < BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sda_lvl_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            state_next = PORT_ACK;
            if (byte_idx_reg == 2'd0) begin
              rd_next = shift_reg[0];
              if (shift_reg[7:1] != DEV_ADDR) begin
                state_next = PORT_IDLE; // Not ours: stay off the bus
              end
            end else if (byte_idx_reg == 2'd1) begin
              ptr_next = shift_reg;
            end else begin
              // All eight bits store, reserved ones included
              case (ptr_reg)
                ADJUST_OFFSET: begin
                  regs_next.thermal_charge_adjust = shift_reg;
                end
                COLD_OFFSET: regs_next.lowest_temp_limit = shift_reg;
                COOL_OFFSET: regs_next.chill_temp_limit = shift_reg;
                WARM_OFFSET: begin
                  regs_next.elevated_temp_limit = shift_reg;
                end
                default: regs_next = regs_reg;
              endcase
              ptr_next = 8'(ptr_reg + 8'h01);
            end
            if (byte_idx_reg != 2'd2) begin
              byte_idx_next = byte_idx_reg + 2'd1;
            end
          end
        end
        PORT_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (rd_reg) begin
              state_next = PORT_TX;
              shift_next = read_reg(regs_reg, ptr_reg);
              ptr_next = 8'(ptr_reg + 8'h01);
            end else begin
              state_next = PORT_RX;
            end
          end
        end
        PORT_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE - 4'h1) begin
              state_next = PORT_ACK_IN;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        PORT_ACK_IN: begin
          if (scl_rise) begin
            nack_next = sda_lvl_reg;
          end else if (scl_fall) begin
            // Host acknowledge asks for the next byte; a nack ends the read
            if (nack_reg) begin
              state_next = PORT_IDLE;
            end else begin
              state_next = PORT_TX;
              bit_cnt_next = 4'h0;
              shift_next = read_reg(regs_reg, ptr_reg);
              ptr_next = 8'(ptr_reg + 8'h01);
            end
          end
        end
        default: begin
          state_next = PORT_IDLE;
        end
      endcase
    end
    // Pull low for our acknowledge and for each zero data bit
    sda_oe_next = (state_next == PORT_ACK) ||
      (state_next == PORT_TX && !shift_next[7]);
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PORT_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      byte_idx_reg <= 2'd0;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      regs_reg.thermal_charge_adjust <= ADJUST_RESET;
      regs_reg.lowest_temp_limit <= COLD_RESET;
      regs_reg.chill_temp_limit <= COOL_RESET;
      regs_reg.elevated_temp_limit <= WARM_RESET;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      byte_idx_reg <= byte_idx_next;
      rd_reg <= rd_next;
      nack_reg <= nack_next;
      sda_oe_reg <= sda_oe_next;
      regs_reg <= regs_next;
    end
  end

  // Open drain: only ever drive low
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_reg;

  // ----------------------------------------------------------------------
  // Zone evaluation
  // ----------------------------------------------------------------------
  temp_zone_eval #(
    .CUR_W(CUR_W)
  ) u_zone (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .ts_code_in(ts_code_in),
    .regs_in(regs_reg),
    .programmed_fast_current_in(programmed_fast_current_in),
    .zone_out(zone_out),
    .vbat_drop_mv_out(vbat_drop_mv_out),
    .fast_current_out(fast_current_out),
    .charge_hold_out(charge_hold_out)
  );

endmodule : thermal_charge_profile_regs

// >>> tb/profile_regs_assertions.sv
/* Checker of the profile register bank: serial port and zone outputs.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps

module profile_regs_checker #(
  parameter int CUR_W = 10
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [7:0] ts_code_in,
  input wire logic [CUR_W-1:0] programmed_fast_current_in,
  input wire thermal_profile_pkg::zone_t zone_out,
  input wire logic [8:0] vbat_drop_mv_out,
  input wire logic [CUR_W-1:0] fast_current_out,
  input wire logic charge_hold_out
);
  import thermal_profile_pkg::*;
  logic [1:0] up_cnt_reg;
  logic [1:0] up_cnt_next;
  // Edges since release; the reset pipe hides outputs before count 3
  always_comb begin
    up_cnt_next = (up_cnt_reg == 2'h3) ? up_cnt_reg : up_cnt_reg + 2'h1;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt_reg <= 2'h0;
    end else begin
      up_cnt_reg <= up_cnt_next;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_live;
    up_cnt_reg == 2'h3;
  endsequence
  sequence s_ts_top;
    up_cnt_reg == 2'h3 && ts_code_in == 8'hFF;
  endsequence
  a_data_value_low: assert property (sda_out == 1'b0)
    else $error("data value not low");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |->
    !sda_oe_out && zone_out == ZONE_NORMAL && !charge_hold_out)
    else $error("outputs active in reset");
  a_ack_in_low: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("data pulled while clock high");
  a_release_in_low: assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("data released while clock high");
  a_drop_only_warm: assert property (
    zone_out != ZONE_WARM |-> vbat_drop_mv_out == 9'h000)
    else $error("drop outside warm zone");
  a_drop_step_grid: assert property (vbat_drop_mv_out <= 9'h15E &&
    vbat_drop_mv_out % DROP_STEP_MV == 0) else $error("drop off grid");
  a_hold_means_cold: assert property (
    charge_hold_out == (zone_out == ZONE_COLD)) else $error("hold wrong");
  a_full_current_pass: assert property (s_live ##0
    (zone_out inside {ZONE_NORMAL, ZONE_COLD}) |->
    fast_current_out == $past(programmed_fast_current_in))
    else $error("current altered outside cool or warm");
  a_scaled_current_range: assert property (s_live ##0
    (zone_out inside {ZONE_COOL, ZONE_WARM}) |->
    fast_current_out <= $past(programmed_fast_current_in) &&
    fast_current_out >= ($past(programmed_fast_current_in) >> 3))
    else $error("scaled current out of range");
  a_top_code_cold: assert property (s_ts_top |=>
    zone_out == ZONE_COLD) else $error("top code not cold");
endmodule : profile_regs_checker

bind thermal_charge_profile_regs profile_regs_checker #(.CUR_W(CUR_W)) chk_u (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .ts_code_in(ts_code_in),
  .programmed_fast_current_in(programmed_fast_current_in),
  .zone_out(zone_out), .vbat_drop_mv_out(vbat_drop_mv_out),
  .fast_current_out(fast_current_out), .charge_hold_out(charge_hold_out));

// >>> tb/serial_host_model.sv
/* Two-wire host model for the register port.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/10ps

module serial_host_model (
  input wire logic clk_in,
  input wire logic sda_wire_in,
  output logic scl_out,
  output logic sda_out
);
  // Idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic start_cond();
    tick(4);
    sda_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(8);
    sda_out <= 1'b0;
    tick(8);
    scl_out <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    tick(4);
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(8);
    sda_out <= 1'b1;
    tick(8);
  endtask : stop_cond
  // Data moves mid low phase, so no false start or stop is seen
  task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(4);
      sda_out <= tx[i];
      tick(4);
      scl_out <= 1'b1;
      tick(8);
      rx[i] = sda_wire_in;
      scl_out <= 1'b0;
    end
  endtask : xfer9
endmodule : serial_host_model

// >>> tb/thermal_charge_profile_regs_tb.sv
/* Self-checking bench: reset values, read back, foreign address, zones.
   Assumes the host model owns the serial lines. */
`timescale 1ns/10ps

module thermal_charge_profile_regs_tb;
  import thermal_profile_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic scl, host_sda, sda_val, sda_oe, sda_wire, hold;
  logic [7:0] ts = 8'h00;
  logic [9:0] cur = 10'h000;
  logic [9:0] cur_out;
  logic [8:0] drop;
  zone_t zone;
  logic [7:0] wbuf [5];
  logic [7:0] rbuf [4];
  logic [7:0] shadow [4];
  int error_cnt = 0;
  int checks_done = 0;

  always #5 clk = ~clk;
  // Pull-up wire, low while either side pulls
  assign sda_wire = host_sda & (sda_oe ? sda_val : 1'b1);

  thermal_charge_profile_regs dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_val), .sda_oe_out(sda_oe),
    .ts_code_in(ts), .programmed_fast_current_in(cur), .zone_out(zone),
    .vbat_drop_mv_out(drop), .fast_current_out(cur_out),
    .charge_hold_out(hold));
  serial_host_model host_u (.clk_in(clk), .sda_wire_in(sda_wire),
    .scl_out(scl), .sda_out(host_sda));

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [6:0] dev, input int n, output logic miss);
    logic [8:0] rx;
    host_u.start_cond();
    host_u.xfer9({dev, 2'b01}, rx);
    miss = rx[0];
    for (int i = 0; i < n; i++) host_u.xfer9({wbuf[i], 1'b1}, rx);
    host_u.stop_cond();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input int n);
    logic [8:0] rx;
    host_u.start_cond();
    host_u.xfer9({DEFAULT_DEV_ADDR, 2'b01}, rx);
    host_u.xfer9({ptr, 1'b1}, rx);
    host_u.start_cond();
    host_u.xfer9({DEFAULT_DEV_ADDR, 2'b11}, rx);
    for (int i = 0; i < n; i++) begin
      host_u.xfer9({8'hFF, i == n - 1}, rx);
      rbuf[i] = rx[8:1];
    end
    host_u.stop_cond();
  endtask : rd
  function automatic zone_t exp_zone(input logic [7:0] t);
    if (t >= shadow[1]) return ZONE_COLD;
    if (t >= shadow[2]) return ZONE_COOL;
    if (t <= shadow[3]) return ZONE_WARM;
    return ZONE_NORMAL;
  endfunction : exp_zone
  // One code in, all four zone outputs compared two cycles later
  task automatic probe(input logic [7:0] t);
    zone_t z;
    z = exp_zone(t);
    @(posedge clk);
    ts <= t;
    cur <= 10'($urandom_range(0, 1023));
    repeat (2) @(posedge clk);
    #1;
    check("zone", 16'(zone), 16'(z));
    check("hold", 16'(hold), 16'(z == ZONE_COLD));
    check("drop", 16'(drop), (z == ZONE_WARM) ?
      16'(shadow[0][6:4]) * 16'h0032 : 16'h0000);
    check("current", 16'(cur_out), z inside {ZONE_COOL, ZONE_WARM} ?
      16'(int'(cur) * (8 - int'(shadow[0][2:0])) / 8) : 16'(cur));
  endtask : probe

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic miss;
    logic [7:0] corner [8];
    // Real falling edge at time zero so the async reset acts before edge one
    rst_n <= 1'b0;
    void'($urandom(32));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    shadow = '{ADJUST_RESET, COLD_RESET, COOL_RESET, WARM_RESET};
    rd(ADJUST_OFFSET, 4);
    for (int i = 0; i < 4; i++) begin
      check("reset", 16'(rbuf[i]), 16'(shadow[i]));
    end
    rd(8'h65, 1);
    check("unmapped", 16'(rbuf[0]), 16'(UNMAPPED_READ));
    $display("test done: reset values");
    shadow = '{8'($urandom), 8'hC0 | 8'($urandom % 64),
      8'h60 + 8'($urandom % 32), 8'h30 + 8'($urandom % 32)};
    wbuf = '{ADJUST_OFFSET, shadow[0], shadow[1], shadow[2], shadow[3]};
    wr(DEFAULT_DEV_ADDR, 5, miss);
    check("ack", 16'(miss), 16'h0000);
    rd(ADJUST_OFFSET, 4);
    for (int i = 0; i < 4; i++) begin
      check("readback", 16'(rbuf[i]), 16'(shadow[i]));
    end
    $display("test done: write and read back");
    wbuf[1] = ~shadow[0];
    wr(DEFAULT_DEV_ADDR ^ 7'h01, 2, miss);
    check("foreign ack", 16'(miss), 16'h0001);
    rd(ADJUST_OFFSET, 1);
    check("untouched", 16'(rbuf[0]), 16'(shadow[0]));
    $display("test done: foreign address");
    for (int n = 0; n < 8; n++) begin
      shadow[0] = {1'($urandom), 3'(n), 1'($urandom), 3'(7 - n)};
      wbuf[1] = shadow[0];
      wr(DEFAULT_DEV_ADDR, 2, miss);
      corner = '{shadow[1], shadow[1] - 8'h01, shadow[2], shadow[2] - 8'h01,
        shadow[3], shadow[3] + 8'h01, 8'hFF, 8'h00};
      for (int k = 0; k < 12; k++) probe(k < 8 ? corner[k] : 8'($urandom));
    end
    $display("test done: zone sweep");
    // Mid-run reset must bring every written register back to its default
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    shadow = '{ADJUST_RESET, COLD_RESET, COOL_RESET, WARM_RESET};
    rd(ADJUST_OFFSET, 4);
    for (int i = 0; i < 4; i++) begin
      check("rereset", 16'(rbuf[i]), 16'(shadow[i]));
    end
    $display("test done: mid-run reset");
    wrap_up();
  end
endmodule : thermal_charge_profile_regs_tb
